/* File: design/lcf_params.svh */
// Constants for the loop output configuration register block
`ifndef LCF_PARAMS_SVH
`define LCF_PARAMS_SVH

`define LCF_ADDR_W            8
`define LCF_OFF_CONFIG        8'h00
`define LCF_OFF_STATUS        8'h04
`define LCF_OFF_MOTOR         8'h08
`define LCF_CONFIG_RESET      32'h0000_0000
`define LCF_CONFIG_WMASK      32'h0007_fffd
`define LCF_BIT_BRAKE         0
`define LCF_BIT_RSVD          1
`define LCF_BIT_DTC           2
`define LCF_BIT_SURGE         3
`define LCF_LSB_THR           4
`define LCF_BIT_ACT           7
`define LCF_LSB_DIV           8
`define LCF_LSB_SRC           12
`define LCF_BIT_MOD           14
`define LCF_LSB_PWM           15
`define LCF_PWM_MAX_CODE      4'ha
`define LCF_THR_MAX_CODE      3'h5
`define LCF_SRC_MAX_CODE      2'h2
`define LCF_PWM_BASE_KHZ      10
`define LCF_PWM_STEP_KHZ      5
`define LCF_CLK_KHZ           100000
`define LCF_DIV3_PULSES       3
`define LCF_STOP_RECIRC       3'h1

`endif

/* File: design/lcf_pkg.sv */
// Types for the loop output configuration register block
package lcf_pkg;

  typedef enum logic [1:0] {
    LCF_SRC_ALL,
    LCF_SRC_CLOSED,
    LCF_SRC_FIRST_OPEN,
    LCF_SRC_BAD
  } lcf_src_t;

  typedef enum logic [2:0] {
    LCF_MS_IDLE,
    LCF_MS_ISD,
    LCF_MS_ALIGN,
    LCF_MS_OPEN,
    LCF_MS_CLOSED,
    LCF_MS_STOP
  } lcf_motor_t;

  typedef struct packed {
    logic [3:0] pwm_freq;
    logic       modulation_dsvm;
    logic [1:0] speed_pulse_source_select;
    logic [3:0] speed_pulse_divider;
    logic       speed_pulse_activity_config;
    logic [2:0] speed_pulse_backemf_threshold;
    logic       surge_protection_enable;
    logic       deadtime_comp_enable;
    logic       slow_stop_brake_select;
  } lcf_cfg_t;

  typedef struct packed {
    logic [2:0] state;
    logic       first_try;
    logic       backemf_below;
    logic [2:0] stop_mode;
  } lcf_motor_in_t;

endpackage

/* File: design/lcf_pulse_div.sv */
// Speed pulse divider: counts electrical edges into the speed pulse output
`timescale 1ns/1ps
`default_nettype none
`include "lcf_params.svh"

module lcf_pulse_div #(
  parameter int DIV_W = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             enable_i,
  input  wire logic [DIV_W-1:0] divider_i,
  input  wire logic             elec_cycle_i,
  input  wire logic             third_cycle_i,
  output logic                  pulse_o
);

  logic [DIV_W-1:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // One-clock pulses: toggling would halve the pulse rate
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      count   <= '0;
      pulse_o <= 1'b0;
    end else if (divider_i == '0) begin
      pulse_o <= third_cycle_i;
    end else if (elec_cycle_i) begin
      if (count >= divider_i - 1'b1) begin
        count   <= '0;
        pulse_o <= 1'b1;
      end else begin
        count   <= count + 1'b1;
        pulse_o <= 1'b0;
      end
    end else begin
      pulse_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: design/lcf_config_regs.sv */
// Loop output configuration register with Wishbone slave and output control
//
// Functional notes
// - Bit 14 clear selects continuous, set selects discontinuous space vector modulation.
// - Source code zero: speed pulse in initial detection, open and closed loop.
// - Source code one: speed pulse only in closed loop.
// - Source code two adds open loop on first try; code three invalid.
// - Divider zero gives three pulses per cycle, else divide by value.
// - Activity bit clear: speed pulse active while motor is driven.
// - Activity bit set: speed pulse active until back-EMF below threshold.
// - Threshold codes zero to five give 1 to 30 mV; six, seven invalid.
// - Recirculation stop in align or open loop: bit 0 picks Hi-Z or brake.
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lcf_params.svh"

module lcf_config_regs #(
  parameter int AW = `LCF_ADDR_W
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [AW-1:0]          wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire lcf_pkg::lcf_motor_in_t motor_i,
  input  wire logic                   elec_cycle_i,
  input  wire logic                   third_cycle_i,
  output lcf_pkg::lcf_cfg_t           cfg_o,
  output logic      [15:0]            pwm_period_o,
  output logic                        speed_pulse_output_o,
  output logic                        phase_hiz_o,
  output logic                        low_side_brake_o,
  output logic                        cfg_error_o
);

  logic [31:0]       config_q;
  logic [31:0]       next_config;
  logic [31:0]       status_word;
  logic              wb_hit;
  logic              pulse_en_q;
  logic              next_pulse_en;
  logic              driving;
  logic              pulse_raw;
  logic [3:0]        next_pwm;
  logic [2:0]        next_thr;
  logic [1:0]        next_src;
  logic [3:0]        pwm_code;
  lcf_pkg::lcf_src_t src;

  assign wb_hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign pwm_code = config_q[`LCF_LSB_PWM +: 4];
  assign src      = lcf_pkg::lcf_src_t'(config_q[`LCF_LSB_SRC +: 2]);
  assign driving  = (motor_i.state != lcf_pkg::LCF_MS_IDLE) &&
                    (motor_i.state != lcf_pkg::LCF_MS_STOP);

  ////////////////////////////////////////////////////////////////////////////
  // Write merge: byte lanes, read-only reserved bit, invalid codes refused
  always_comb begin
    next_config = config_q;
    for (int i = 0; i < 4; i++) begin
      if (wb_sel_i[i]) begin
        next_config[i*8 +: 8] = wb_dat_i[i*8 +: 8];
      end
    end
    next_config = (next_config & `LCF_CONFIG_WMASK) | (config_q & ~`LCF_CONFIG_WMASK);
    next_config[`LCF_BIT_RSVD] = 1'b0;
    next_pwm = next_config[`LCF_LSB_PWM +: 4];
    next_thr = next_config[`LCF_LSB_THR +: 3];
    next_src = next_config[`LCF_LSB_SRC +: 2];
    if (next_pwm > `LCF_PWM_MAX_CODE) begin
      next_config[`LCF_LSB_PWM +: 4] = pwm_code;
    end
    if (next_thr > `LCF_THR_MAX_CODE) begin
      next_config[`LCF_LSB_THR +: 3] = config_q[`LCF_LSB_THR +: 3];
    end
    if (next_src > `LCF_SRC_MAX_CODE) begin
      next_config[`LCF_LSB_SRC +: 2] = config_q[`LCF_LSB_SRC +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored at the edge where ack is high, so a held request commits once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_q    <= `LCF_CONFIG_RESET;
      cfg_error_o <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                 wb_adr_i == `LCF_OFF_CONFIG) begin
      config_q    <= next_config;
      cfg_error_o <= (next_pwm > `LCF_PWM_MAX_CODE) || (next_thr > `LCF_THR_MAX_CODE) ||
                     (next_src > `LCF_SRC_MAX_CODE);
    end
  end

  assign status_word = {24'h00_0000, motor_i.stop_mode, motor_i.backemf_below,
                        motor_i.first_try, motor_i.state};

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          `LCF_OFF_CONFIG: wb_dat_o <= config_q;
          `LCF_OFF_STATUS: wb_dat_o <= {31'h0000_0000, speed_pulse_output_o};
          `LCF_OFF_MOTOR:  wb_dat_o <= status_word;
          default:         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded fields out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.pwm_freq                      <= pwm_code;
      cfg_o.modulation_dsvm               <= config_q[`LCF_BIT_MOD];
      cfg_o.speed_pulse_source_select     <= config_q[`LCF_LSB_SRC +: 2];
      cfg_o.speed_pulse_divider           <= config_q[`LCF_LSB_DIV +: 4];
      cfg_o.speed_pulse_activity_config   <= config_q[`LCF_BIT_ACT];
      cfg_o.speed_pulse_backemf_threshold <= config_q[`LCF_LSB_THR +: 3];
      cfg_o.surge_protection_enable       <= config_q[`LCF_BIT_SURGE];
      cfg_o.deadtime_comp_enable          <= config_q[`LCF_BIT_DTC];
      cfg_o.slow_stop_brake_select        <= config_q[`LCF_BIT_BRAKE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM period in clocks; codes stay within the legal range
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_period_o <= 16'(`LCF_CLK_KHZ / `LCF_PWM_BASE_KHZ);
    end else begin
      pwm_period_o <= 16'(`LCF_CLK_KHZ /
                      (`LCF_PWM_BASE_KHZ + `LCF_PWM_STEP_KHZ * int'(pwm_code)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed pulse gating by motor state and source select
  always_comb begin
    next_pulse_en = 1'b0;
    unique case (src)
      lcf_pkg::LCF_SRC_ALL: begin
        next_pulse_en = motor_i.state inside {lcf_pkg::LCF_MS_ISD, lcf_pkg::LCF_MS_OPEN,
                                              lcf_pkg::LCF_MS_CLOSED};
      end
      lcf_pkg::LCF_SRC_CLOSED: begin
        next_pulse_en = motor_i.state == lcf_pkg::LCF_MS_CLOSED;
      end
      lcf_pkg::LCF_SRC_FIRST_OPEN: begin
        next_pulse_en = (motor_i.state == lcf_pkg::LCF_MS_CLOSED) ||
                        (motor_i.state == lcf_pkg::LCF_MS_OPEN && motor_i.first_try);
      end
      lcf_pkg::LCF_SRC_BAD: begin
        next_pulse_en = 1'b0;
      end
    endcase
    if (!config_q[`LCF_BIT_ACT]) begin
      next_pulse_en = next_pulse_en && driving;
    end else begin
      next_pulse_en = next_pulse_en && !motor_i.backemf_below;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_en_q <= 1'b0;
    end else begin
      pulse_en_q <= next_pulse_en;
    end
  end

  lcf_pulse_div #(
    .DIV_W(4)
  ) u_div (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .enable_i     (pulse_en_q),
    .divider_i    (config_q[`LCF_LSB_DIV +: 4]),
    .elec_cycle_i (elec_cycle_i),
    .third_cycle_i(third_cycle_i),
    .pulse_o      (pulse_raw)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_pulse_output_o <= 1'b0;
    end else begin
      speed_pulse_output_o <= pulse_raw && pulse_en_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-speed stop during recirculation in align or open loop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_hiz_o      <= 1'b0;
      low_side_brake_o <= 1'b0;
    end else if (motor_i.stop_mode == `LCF_STOP_RECIRC &&
                 (motor_i.state == lcf_pkg::LCF_MS_ALIGN ||
                  motor_i.state == lcf_pkg::LCF_MS_OPEN)) begin
      phase_hiz_o      <= !config_q[`LCF_BIT_BRAKE];
      low_side_brake_o <= config_q[`LCF_BIT_BRAKE];
    end else begin
      phase_hiz_o      <= 1'b0;
      low_side_brake_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: test/lcf_asserts.sv */
// Checker of the loop output configuration register block
`timescale 1ns/1ps
`default_nettype none
`include "lcf_params.svh"
module lcf_asserts #(
  parameter int AW = 8
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [AW-1:0]          wb_adr_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire lcf_pkg::lcf_motor_in_t motor_i,
  input wire lcf_pkg::lcf_cfg_t      cfg_o,
  input wire logic [15:0]            pwm_period_o,
  input wire logic                   speed_pulse_output_o,
  input wire logic                   phase_hiz_o,
  input wire logic                   low_side_brake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Windows of four cycles cover the two cycle output latency
  logic slow;
  assign slow = motor_i.stop_mode == `LCF_STOP_RECIRC &&
                motor_i.state inside {lcf_pkg::LCF_MS_ALIGN, lcf_pkg::LCF_MS_OPEN};
  //////////////////////////////
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_rsvd_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == '0 |-> {wb_dat_o[31:19], wb_dat_o[1]} == 14'h0)
    else $error("reserved bits read nonzero");
  a_src_valid: assert property (cfg_o.speed_pulse_source_select != 2'h3)
    else $error("invalid source code applied");
  a_pwm_period: assert property ($stable(cfg_o.pwm_freq) [*3] |-> pwm_period_o ==
    16'(`LCF_CLK_KHZ / (`LCF_PWM_BASE_KHZ + `LCF_PWM_STEP_KHZ * cfg_o.pwm_freq)))
    else $error("pwm period wrong");
  a_closed_only: assert property (
    (cfg_o.speed_pulse_source_select == 2'h1 && motor_i.state != lcf_pkg::LCF_MS_CLOSED) [*4]
    |-> !speed_pulse_output_o) else $error("speed pulse outside closed loop");
  a_idle_quiet: assert property (
    (motor_i.state == lcf_pkg::LCF_MS_IDLE) [*4] |-> !speed_pulse_output_o)
    else $error("speed pulse while idle");
  a_bemf_cut: assert property (
    (cfg_o.speed_pulse_activity_config && motor_i.backemf_below) [*4] |-> !speed_pulse_output_o)
    else $error("speed pulse below back-EMF threshold");
  a_slow_stop: assert property (
    (slow && $stable(cfg_o.slow_stop_brake_select)) [*4] |->
    {low_side_brake_o, phase_hiz_o} ==
    {cfg_o.slow_stop_brake_select, !cfg_o.slow_stop_brake_select})
    else $error("slow stop outputs wrong");
endmodule
bind lcf_config_regs lcf_asserts #(.AW(AW)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .motor_i(motor_i), .cfg_o(cfg_o), .pwm_period_o(pwm_period_o),
  .speed_pulse_output_o(speed_pulse_output_o), .phase_hiz_o(phase_hiz_o),
  .low_side_brake_o(low_side_brake_o));
`default_nettype wire

/* File: test/testbench.sv */
// Random and corner tests of the loop output configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "lcf_params.svh"
module testbench;
  logic                   clk_i, rst_i, cyc, stb, we, el, th, ack, spo, hiz, brk, err;
  logic [7:0]             adr;
  logic [3:0]             sel;
  logic [31:0]            wd, dq, rd, sh;
  logic [15:0]            per;
  lcf_pkg::lcf_motor_in_t mot;
  lcf_pkg::lcf_cfg_t      cfg;
  int                     bad_count, n_tests, t, e;
  int                     dv [4] = '{0, 2, 3, 15};
  lcf_config_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dq),
    .wb_ack_o(ack), .motor_i(mot), .elec_cycle_i(el), .third_cycle_i(th), .cfg_o(cfg),
    .pwm_period_o(per), .speed_pulse_output_o(spo), .phase_hiz_o(hiz),
    .low_side_brake_o(brk), .cfg_error_o(err));
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  //////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (x !== g) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int i;
    {cyc, stb, we, adr, wd, sel} <= {2'h3, w, a, d, s};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'h1 && i < 20);
    rd = dq;
    {cyc, stb} <= 2'h0;
    if (ack !== 1'h1) begin
      bad_count++;
      stop_test();
    end
    @(posedge clk_i);
  endtask
  function automatic logic [32:0] upd(logic [31:0] o, logic [31:0] d, logic [3:0] s);
    logic [31:0] m, v;
    logic        x;
    for (int b = 0; b < 4; b++) m[b*8+:8] = {8{s[b]}};
    v = ((o & ~m) | (d & m)) & `LCF_CONFIG_WMASK;
    x = v[18:15] > 4'ha || v[6:4] > 3'h5 || v[13:12] == 2'h3;
    if (v[18:15] > 4'ha) v[18:15] = o[18:15];
    if (v[6:4] > 3'h5) v[6:4] = o[6:4];
    if (v[13:12] == 2'h3) v[13:12] = o[13:12];
    return {x, v};
  endfunction
  function automatic logic en(logic [1:0] s, logic [2:0] st, logic f);
    case (st)
      lcf_pkg::LCF_MS_ISD:    return s == 2'h0;
      lcf_pkg::LCF_MS_OPEN:   return s == 2'h0 || (s == 2'h2 && f);
      lcf_pkg::LCF_MS_CLOSED: return 1'h1;
      default:                return 1'h0;
    endcase
  endfunction
  function automatic logic [31:0] rnd();
    logic [31:0] r;
    r = $urandom;
    r[18:15] = 4'($urandom_range(10));
    r[13:12] = 2'($urandom_range(2));
    r[6:4] = 3'($urandom_range(5));
    return r;
  endfunction
  task automatic wcfg(logic [31:0] d, logic [3:0] s);
    logic [32:0] r;
    r = upd(sh, d, s);
    sh = r[31:0];
    bus(1'h1, 8'h00, d, s);
    bus(1'h0, 8'h00, 32'h0, 4'hf);
    chk("readback", sh, rd);
    chk("fields", {sh[18:2], sh[0]}, cfg);
    chk("error", r[32], err);
    chk("period", 16'(`LCF_CLK_KHZ / (10 + 5 * sh[18:15])), per);
  endtask
  task automatic sp(lcf_pkg::lcf_motor_in_t m, int k, logic tr, int x);
    mot <= m;
    repeat (4) @(posedge clk_i);
    t = 0;
    repeat (k) begin
      {el, th} <= {!tr, tr};
      @(posedge clk_i);
      {el, th} <= 2'h0;
      // One-clock pulses: count the cycles the output stands high
      repeat (3) begin
        @(posedge clk_i);
        t += int'(spo === 1'h1);
      end
    end
    chk("pulses", x, t);
  endtask
  //////////////////////////////
  initial begin
    {rst_i, cyc, stb, we, el, th, adr, sel, wd, mot, sh} = {6'h20, 84'h0};
    bad_count = 0;
    n_tests = 0;
    t = $urandom(31659);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    bus(1'h0, 8'h00, 32'h0, 4'hf);
    chk("reset", 32'h0, rd);
    chk("reset period", 16'h2710, per);
    bus(1'h0, 8'h0c, 32'h0, 4'hf);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    for (int c = 11; c < 16; c++) begin
      wcfg({13'h0, 4'(c), 1'h1, 2'(c), 5'h1f, 3'(c), 4'h5}, 4'hf);
    end
    repeat (20) wcfg(rnd(), 4'hf);
    wcfg(32'hfffd_6fdf, 4'hf);
    repeat (8) wcfg(rnd(), 4'($urandom_range(1, 15)));
    bus(1'h1, 8'h10, 32'hffff_ffff, 4'hf);
    bus(1'h0, 8'h00, 32'h0, 4'hf);
    chk("ignored write", sh, rd);
    $display("test register done");
    for (int s = 0; s < 3; s++) begin
      wcfg({18'h0, 2'(s), 4'h1, 8'h0}, 4'hf);
      for (int st = 0; st < 6; st++) begin
        for (int f = 0; f < 2; f++) begin
          e = en(2'(s), 3'(st), 1'(f)) ? 4 : 0;
          sp({3'(st), 1'(f), 4'h0}, 4, 1'h0, e);
        end
      end
    end
    $display("test source done");
    foreach (dv[i]) begin
      wcfg({20'h0, 4'(dv[i]), 8'h0}, 4'hf);
      sp({lcf_pkg::LCF_MS_CLOSED, 5'h0}, 30, dv[i] == 0, dv[i] == 0 ? 30 : 30 / dv[i]);
    end
    wcfg(32'h0000_0180, 4'hf);
    sp({lcf_pkg::LCF_MS_CLOSED, 5'h08}, 4, 1'h0, 0);
    sp({lcf_pkg::LCF_MS_CLOSED, 5'h00}, 4, 1'h0, 4);
    wcfg(32'h0000_0100, 4'hf);
    sp({lcf_pkg::LCF_MS_CLOSED, 5'h08}, 4, 1'h0, 4);
    $display("test divider done");
    for (int b = 0; b < 4; b++) begin
      wcfg({31'h0, 1'(b)}, 4'hf);
      mot <= {b[1] ? lcf_pkg::LCF_MS_OPEN : lcf_pkg::LCF_MS_ALIGN, 5'h01};
      repeat (4) @(posedge clk_i);
      chk("brake", {b[0], !b[0]}, {brk, hiz});
      bus(1'h0, 8'h08, 32'h0, 4'hf);
      chk("motor echo", {24'h0, mot.stop_mode, mot.backemf_below, mot.first_try, mot.state},
          rd);
    end
    mot <= {lcf_pkg::LCF_MS_OPEN, 5'h02};
    repeat (4) @(posedge clk_i);
    chk("no slow stop", 32'h0, {brk, hiz});
    $display("test brake done");
    stop_test();
  end
endmodule
`default_nettype wire
